/* logic/erb_top.sv */
// Configurable 4096-bit embedded RAM block with AXI4-Lite configuration port
//
// Contract
// [RULE1] Storage array holds exactly 4096 bits
// [RULE2] Shapes 256x16, 512x8, 1024x4, 2048x2
// [RULE3] Single-port or dual-port mode by configuration
// [RULE4] Write and read sections run at separate rates
// [RULE5] Each section has its own clock enable
// [RULE6] Alternative: input enable versus output enable
// [RULE7] Write strobe generated internally from write clock
// [RULE8] Six input/output registers each individually bypassable
// [RULE9] All registers asynchronously clearable; the AXI4-Lite channel registers take only the synchronous sys_rst_i
// [RULE10] Lookup mode: preloaded read-only combinational table
// [RULE11] Blocks combine side by side for width
// [RULE12] Blocks cascade in depth to 2048 words
// [RULE13] True dual port built from two blocks
// [RULE14] User logic drives enables, clears and clocks
// [RULE15] Disabled read leaves registered output holding
`timescale 1ns/100ps
module erb_top
  import erb_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic local_clr_i,
  input wire logic global_clr_i,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [4:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // User write section
  input wire logic [10:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic wr_ce_i,
  // User read section
  input wire logic [10:0] rd_addr_i,
  input wire logic rd_en_i,
  input wire logic rd_ce_i,
  // Block select for depth cascading
  input wire logic blk_sel_i,
  output logic [15:0] rd_data_o
);

  // ---------------------------------------------------------------------------
  // Shape helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] word_of(input logic [10:0] a, input logic [1:0] s);
    logic [10:0] t;
    t = a >> s;
    word_of = t[7:0];
  endfunction : word_of

  function automatic logic [3:0] lane_sh(input logic [10:0] a, input logic [1:0] s);
    unique case (s)
      2'b00: lane_sh = 4'h0;
      2'b01: lane_sh = {a[0], 3'b000};
      2'b10: lane_sh = {a[1:0], 2'b00};
      2'b11: lane_sh = {a[2:0], 1'b0};
    endcase
  endfunction : lane_sh

  function automatic logic [15:0] lane_mask(input logic [1:0] s);
    unique case (s)
      2'b00: lane_mask = 16'hffff;
      2'b01: lane_mask = 16'h00ff;
      2'b10: lane_mask = 16'h000f;
      2'b11: lane_mask = 16'h0003;
    endcase
  endfunction : lane_mask

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_strb = r;
  endfunction : merge_strb

  // ---------------------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------------------
  logic [10:0] cfg_q;
  logic [10:0] cfg_d;
  logic [10:0] pre_addr_q;
  logic [10:0] pre_addr_d;
  logic [1:0] cfg_shape;
  logic cfg_dual;
  logic cfg_rom;
  logic cfg_split;

  assign cfg_shape = cfg_q[ERB_CFG_SHAPE_LSB +: 2]; // [RULE2]
  assign cfg_dual = cfg_q[ERB_CFG_DUAL_BIT];
  assign cfg_rom = cfg_q[ERB_CFG_ROM_BIT];
  assign cfg_split = cfg_q[ERB_CFG_SPLIT_BIT];

  // ---------------------------------------------------------------------------
  // Storage array
  // ---------------------------------------------------------------------------
  logic [15:0] mem [ERB_WORDS]; // [RULE1]

  // ---------------------------------------------------------------------------
  // Clocking arrangement and clears
  // ---------------------------------------------------------------------------
  logic arst;
  logic ce_rin;
  logic ce_out;

  assign arst = local_clr_i | global_clr_i; // [RULE9]
  // Split arrangement puts every input register on the write clock enable wr_ce_i
  assign ce_rin = cfg_split ? wr_ce_i : rd_ce_i; // [RULE6] [RULE5]
  assign ce_out = rd_ce_i; // [RULE4]

  // ---------------------------------------------------------------------------
  // Input and output register stages
  // ---------------------------------------------------------------------------
  logic [15:0] din_eff;
  logic [10:0] waddr_eff;
  logic we_eff;
  logic [10:0] raddr_src;
  logic [10:0] raddr_eff;
  logic ren_eff;
  logic [15:0] rd_lane;
  logic dout_en;

  // Single-port mode shares the write address for reading
  assign raddr_src = cfg_dual ? rd_addr_i : wr_addr_i; // [RULE3] [RULE13]
  assign dout_en = ce_out & ren_eff & blk_sel_i; // [RULE15] [RULE12]

  erb_stage #(.W(16)) u_din (
    .clk_i(clk_i),
    .arst_i(arst),
    .srst_i(sys_rst_i),
    .byp_i(cfg_q[ERB_CFG_BYP_DIN_BIT]), // [RULE8]
    .en_i(wr_ce_i), // [RULE5]
    .d_i(wr_data_i),
    .q_o(din_eff)
  );

  erb_stage #(.W(11)) u_waddr (
    .clk_i(clk_i),
    .arst_i(arst),
    .srst_i(sys_rst_i),
    .byp_i(cfg_q[ERB_CFG_BYP_WADDR_BIT]), // [RULE8]
    .en_i(wr_ce_i),
    .d_i(wr_addr_i),
    .q_o(waddr_eff)
  );

  erb_stage #(.W(1)) u_we (
    .clk_i(clk_i),
    .arst_i(arst),
    .srst_i(sys_rst_i),
    .byp_i(cfg_q[ERB_CFG_BYP_WE_BIT]), // [RULE8]
    .en_i(wr_ce_i),
    .d_i(wr_en_i),
    .q_o(we_eff)
  );

  erb_stage #(.W(11)) u_raddr (
    .clk_i(clk_i),
    .arst_i(arst),
    .srst_i(sys_rst_i),
    .byp_i(cfg_q[ERB_CFG_BYP_RADDR_BIT]), // [RULE8]
    .en_i(ce_rin),
    .d_i(raddr_src),
    .q_o(raddr_eff)
  );

  erb_stage #(.W(1)) u_ren (
    .clk_i(clk_i),
    .arst_i(arst),
    .srst_i(sys_rst_i),
    .byp_i(cfg_q[ERB_CFG_BYP_REN_BIT]), // [RULE8]
    .en_i(ce_rin),
    .d_i(rd_en_i),
    .q_o(ren_eff)
  );

  erb_stage #(.W(16)) u_dout (
    .clk_i(clk_i),
    .arst_i(arst),
    .srst_i(sys_rst_i),
    .byp_i(cfg_q[ERB_CFG_BYP_DOUT_BIT]), // [RULE8]
    .en_i(dout_en), // [RULE15]
    .d_i(rd_lane),
    .q_o(rd_data_o) // [RULE11]
  );

  // ---------------------------------------------------------------------------
  // User write path
  // ---------------------------------------------------------------------------
  logic wr_fire;
  logic [7:0] w_idx;
  logic [3:0] w_sh;
  logic [15:0] w_bits;
  logic [15:0] w_val;

  // Internal strobe: the array writes on the clock edge itself, so user
  // logic only has to meet setup and hold to clk_i
  assign wr_fire = wr_ce_i & we_eff & blk_sel_i & ~cfg_rom; // [RULE7] [RULE5] [RULE12]
  assign w_idx = word_of(waddr_eff, cfg_shape); // [RULE2]
  assign w_sh = lane_sh(waddr_eff, cfg_shape);
  assign w_bits = lane_mask(cfg_shape) << w_sh;
  assign w_val = (din_eff & lane_mask(cfg_shape)) << w_sh;

  // ---------------------------------------------------------------------------
  // User read path
  // ---------------------------------------------------------------------------
  logic [7:0] r_idx;
  logic [3:0] r_sh;
  logic [15:0] r_word;

  // Combinational array read; with address and output bypassed the block
  // behaves as a pure lookup function of its address
  assign r_idx = word_of(raddr_eff, cfg_shape);
  assign r_sh = lane_sh(raddr_eff, cfg_shape);
  assign r_word = mem[r_idx];
  assign rd_lane = (r_word >> r_sh) & lane_mask(cfg_shape); // [RULE10]

  // ---------------------------------------------------------------------------
  // Preload path
  // ---------------------------------------------------------------------------
  logic pre_fire;
  logic [7:0] p_idx;
  logic [3:0] p_sh;
  logic [15:0] p_bits;
  logic [15:0] p_val;
  logic [15:0] p_lane;

  assign p_idx = word_of(pre_addr_q, cfg_shape);
  assign p_sh = lane_sh(pre_addr_q, cfg_shape);
  assign p_bits = lane_mask(cfg_shape) << p_sh;
  assign p_lane = (mem[p_idx] >> p_sh) & lane_mask(cfg_shape);

  // ---------------------------------------------------------------------------
  // Array update
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (wr_fire) begin
      mem[w_idx] <= (mem[w_idx] & ~w_bits) | w_val; // [RULE7]
    end else if (pre_fire) begin
      mem[p_idx] <= (mem[p_idx] & ~p_bits) | p_val; // [RULE10]
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  logic aw_have_q;
  logic [4:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_hs;
  logic w_hs;
  logic wr_do;
  logic [4:0] wa;
  logic wsel_cfg;
  logic wsel_pa;
  logic wsel_pd;
  logic wr_ok;
  logic [31:0] cfg_merged;
  logic [31:0] pa_merged;

  assign s_axi_awready_o = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready_o = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign aw_hs = s_axi_awvalid_i & s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i & s_axi_wready_o;
  assign wr_do = aw_have_q & w_have_q;
  assign wa = {aw_addr_q[4:2], 2'b00};
  assign wsel_cfg = (wa == ERB_CFG_OFS);
  assign wsel_pa = (wa == ERB_PRE_ADDR_OFS);
  assign wsel_pd = (wa == ERB_PRE_DATA_OFS);
  assign wr_ok = wsel_cfg | wsel_pa | wsel_pd;
  assign cfg_merged = merge_strb({21'h000000, cfg_q}, w_data_q, w_strb_q);
  assign pa_merged = merge_strb({21'h000000, pre_addr_q}, w_data_q, w_strb_q);
  assign cfg_d = (wr_do & wsel_cfg) ? cfg_merged[10:0] : cfg_q; // [RULE3] [RULE8]
  assign pre_addr_d = (wr_do & wsel_pa) ? pa_merged[10:0] : pre_addr_q;
  // Preload only lands while the block is in lookup mode
  assign pre_fire = wr_do & wsel_pd & cfg_rom; // [RULE10]
  assign p_val = (w_data_q[15:0] & lane_mask(cfg_shape)) << p_sh;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= ERB_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? ERB_RESP_OKAY : ERB_RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      cfg_q <= ERB_CFG_RST; // [RULE9]
      pre_addr_q <= ERB_PRE_ADDR_RST;
    end else if (sys_rst_i) begin
      cfg_q <= ERB_CFG_RST;
      pre_addr_q <= ERB_PRE_ADDR_RST;
    end else begin
      cfg_q <= cfg_d;
      pre_addr_q <= pre_addr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_hs;
  logic [4:0] ra;
  logic [31:0] rd_mux;
  logic rd_ok;

  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;
  assign ra = {s_axi_araddr_i[4:2], 2'b00};
  assign rd_ok = (ra == ERB_CFG_OFS) | (ra == ERB_PRE_ADDR_OFS) |
                 (ra == ERB_PRE_DATA_OFS) | (ra == ERB_STATUS_OFS);
  assign rd_mux = (ra == ERB_CFG_OFS) ? {21'h000000, cfg_q} :
                  (ra == ERB_PRE_ADDR_OFS) ? {21'h000000, pre_addr_q} :
                  (ra == ERB_PRE_DATA_OFS) ? {16'h0000, p_lane} :
                  (ra == ERB_STATUS_OFS) ? {16'h0000, rd_data_o} :
                  32'h00000000;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= ERB_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? ERB_RESP_OKAY : ERB_RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : erb_top

/* inc/erb_pkg.sv */
// Constants and types shared by the embedded RAM block and its testbench
package erb_pkg;

  // ---------------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned ERB_BITS = 4096;
  localparam int unsigned ERB_DATA_W = 16;
  localparam int unsigned ERB_ADDR_W = 11;
  localparam int unsigned ERB_WORDS = ERB_BITS / ERB_DATA_W;
  localparam int unsigned ERB_IDX_W = 8;

  // Depth-by-width shapes; a wider shift narrows the word
  typedef enum logic [1:0] {
    ERB_SHAPE_256X16 = 2'b00,
    ERB_SHAPE_512X8 = 2'b01,
    ERB_SHAPE_1024X4 = 2'b10,
    ERB_SHAPE_2048X2 = 2'b11
  } erb_shape_t;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int unsigned ERB_AXI_AW = 5;
  localparam logic [4:0] ERB_CFG_OFS = 5'h00;
  localparam logic [4:0] ERB_PRE_ADDR_OFS = 5'h04;
  localparam logic [4:0] ERB_PRE_DATA_OFS = 5'h08;
  localparam logic [4:0] ERB_STATUS_OFS = 5'h0c;

  // Configuration register fields
  localparam int unsigned ERB_CFG_W = 11;
  localparam int unsigned ERB_CFG_SHAPE_LSB = 0;
  localparam int unsigned ERB_CFG_DUAL_BIT = 2;
  localparam int unsigned ERB_CFG_ROM_BIT = 3;
  localparam int unsigned ERB_CFG_SPLIT_BIT = 4;
  localparam int unsigned ERB_CFG_BYP_DIN_BIT = 5;
  localparam int unsigned ERB_CFG_BYP_DOUT_BIT = 6;
  localparam int unsigned ERB_CFG_BYP_WADDR_BIT = 7;
  localparam int unsigned ERB_CFG_BYP_WE_BIT = 8;
  localparam int unsigned ERB_CFG_BYP_RADDR_BIT = 9;
  localparam int unsigned ERB_CFG_BYP_REN_BIT = 10;

  // Reset values
  localparam logic [10:0] ERB_CFG_RST = 11'h004;
  localparam logic [10:0] ERB_PRE_ADDR_RST = 11'h000;

  // AXI response codes
  localparam logic [1:0] ERB_RESP_OKAY = 2'b00;
  localparam logic [1:0] ERB_RESP_SLVERR = 2'b10;

endpackage : erb_pkg

/* logic/erb_stage.sv */
// Bypassable pipeline register with asynchronous clear and clock enable
`timescale 1ns/100ps
module erb_stage #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic arst_i,
  input wire logic srst_i,
  input wire logic byp_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] q_q;

  always_ff @(posedge clk_i or posedge arst_i) begin
    if (arst_i) begin
      q_q <= '0;
    end else if (srst_i) begin
      q_q <= '0;
    end else if (en_i) begin
      q_q <= d_i;
    end
  end

  // Bypass hands the input straight through
  assign q_o = byp_i ? d_i : q_q;

endmodule : erb_stage

/* testbench/erb_checker.sv */
// Port-level assertions for the embedded RAM block
`timescale 1ns/100ps
module erb_checker
  import erb_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic local_clr_i,
  input wire logic global_clr_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [4:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [10:0] wr_addr_i,
  input wire logic wr_ce_i,
  input wire logic [10:0] rd_addr_i,
  input wire logic rd_en_i,
  input wire logic rd_ce_i,
  input wire logic blk_sel_i,
  input wire logic [15:0] rd_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ---
  // Checks
  // ---
  property p_hold;
    !rd_ce_i && !wr_ce_i && !s_axi_bvalid_o |=> s_axi_bvalid_o || local_clr_i || global_clr_i
      || $changed(rd_addr_i) || $changed(wr_addr_i) || $changed(rd_en_i)
      || $changed(blk_sel_i) || $stable(rd_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved while disabled");
  property p_clr;
    local_clr_i || global_clr_i |-> rd_data_o == 16'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear left read data");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_ar_block;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_r_lat;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_w_block;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken while busy");
  property p_unmap;
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[4]
      |=> s_axi_rresp_o == ERB_RESP_SLVERR && s_axi_rdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule : erb_checker

/* testbench/erb_user.sv */
// Model of the user logic driving the RAM block sections
`timescale 1ns/100ps
module erb_user (
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  output logic [10:0] wr_addr_o = 11'h0,
  output logic [15:0] wr_data_o = 16'h0,
  output logic wr_en_o = 1'b0,
  output logic [10:0] rd_addr_o = 11'h0,
  output logic rd_en_o = 1'b0
);
  // Present one write synchronously, then release with inverted lines
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_addr_o <= a;
    wr_data_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clk_i);
    wr_addr_o <= ~a;
    wr_data_o <= ~d;
    wr_en_o <= 1'b0;
  endtask : wr
  // Read; sa also drives the write address used in single-port mode
  task automatic rd(input logic [10:0] sa, input logic [10:0] ra, input int lat,
                    output logic [15:0] q);
    @(posedge clk_i);
    wr_addr_o <= sa;
    rd_addr_o <= ra;
    rd_en_o <= 1'b1;
    repeat (lat) @(posedge clk_i);
    #1 q = rd_data_i;
    @(posedge clk_i);
    rd_addr_o <= ~ra;
    rd_en_o <= 1'b0;
  endtask : rd
endmodule : erb_user

/* testbench/erb_top_tb.sv */
// Self-checking bench for the embedded RAM block
`timescale 1ns/100ps
module erb_top_tb
  import erb_pkg::*;
;
  logic clk_i = 0, sys_rst_i = 1, local_clr_i = 0, global_clr_i = 0;
  logic [4:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rs = 32'h3957, rv;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rr;
  logic [10:0] wr_addr_i, rd_addr_i;
  logic [15:0] wr_data_i, rd_data_o, q;
  logic wr_en_i, rd_en_i, wr_ce_i = 1, rd_ce_i = 1, blk_sel_i = 1;
  logic [15:0] mdl [256];
  logic [10:0] bc [4] = '{11'h004, 11'h044, 11'h604, 11'h7e4};
  int bl [4] = '{2, 1, 1, 0};
  int bad_count = 0, num_checks = 0;
  always #10 clk_i = ~clk_i;
  erb_top uut (.clk_i, .sys_rst_i, .local_clr_i, .global_clr_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .wr_addr_i, .wr_data_i, .wr_en_i, .wr_ce_i, .rd_addr_i, .rd_en_i,
    .rd_ce_i, .blk_sel_i, .rd_data_o);
  erb_user u_user (.clk_i, .rd_data_i(rd_data_o), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i), .wr_en_o(wr_en_i), .rd_addr_o(rd_addr_i), .rd_en_o(rd_en_i));
  // ---
  // Helpers
  // ---
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] msk(input int sh);
    return 16'hffff >> (16 - (16 >> sh));
  endfunction : msk
  function automatic logic [15:0] get(input int sh, input logic [10:0] a);
    return (mdl[(a >> sh) & 255] >> ((a & ((1 << sh) - 1)) * (16 >> sh))) & msk(sh);
  endfunction : get
  task automatic put(input int sh, input logic [10:0] a, input logic [15:0] d);
    int p;
    p = (a & ((1 << sh) - 1)) * (16 >> sh);
    mdl[(a >> sh) & 255] = (mdl[(a >> sh) & 255] & ~(msk(sh) << p)) | ((d & msk(sh)) << p);
  endtask : put
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while ((s_axi_awvalid_i && !s_axi_awready_o) || (s_axi_wvalid_i && !s_axi_wready_o));
    repeat (2) @(posedge clk_i);
    s_axi_bready_i <= 1;
    do @(posedge clk_i); while (!s_axi_bvalid_o);
    rr = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask : axw
  task automatic axr(input logic [4:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 0;
    @(posedge clk_i);
    s_axi_rready_i <= 1;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    rv = s_axi_rdata_o;
    rr = s_axi_rresp_o;
    s_axi_rready_i <= 0;
  endtask : axr
  // ---
  // Tests
  // ---
  initial begin
    logic [10:0] a [6];
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 0;
    axr(ERB_CFG_OFS);
    chk("cfg_rst", rv, {21'h0, ERB_CFG_RST});
    axr(ERB_PRE_ADDR_OFS);
    chk("pre_rst", rv, 32'h0);
    axr(5'h14);
    chk("unmapped", {rv[29:0], rr}, {30'h0, ERB_RESP_SLVERR});
    axw(ERB_STATUS_OFS, 32'h3);
    chk("ro_wr", rr, ERB_RESP_SLVERR);
    $display("regs done");
    for (int sh = 0; sh < 4; sh++) begin
      axw(ERB_CFG_OFS, 32'h4 | sh);
      for (int i = 0; i < 6; i++) begin
        rs = lfsr(rs);
        a[i] = rs[10:0] & ((11'h100 << sh) - 11'h1);
        u_user.wr(a[i], rs[31:16]);
        put(sh, a[i], rs[31:16]);
      end
      for (int i = 5; i >= 0; i--) begin
        u_user.rd(~a[i], a[i], 2, q);
        chk("shape_rd", q & msk(sh), get(sh, a[i]));
      end
    end
    axw(ERB_CFG_OFS, 32'h0);
    u_user.wr(11'h5, 16'h6d29);
    u_user.rd(11'h5, ~11'h5, 2, q);
    chk("single", q, 16'h6d29);
    $display("shapes done");
    axw(ERB_CFG_OFS, 32'h4);
    u_user.wr(11'h21, 16'h5a3c);
    u_user.rd(0, 11'h21, 2, q);
    repeat (3) @(posedge clk_i);
    #1 chk("hold_ren", rd_data_o, 16'h5a3c);
    @(posedge clk_i);
    rd_ce_i <= 0;
    wr_ce_i <= 0;
    u_user.wr(11'h21, 16'h0f0f);
    u_user.rd(0, 11'h33, 2, q);
    chk("hold_ce", q, 16'h5a3c);
    @(posedge clk_i);
    rd_ce_i <= 1;
    wr_ce_i <= 1;
    blk_sel_i <= 0;
    u_user.wr(11'h21, 16'h0f0f);
    @(posedge clk_i);
    blk_sel_i <= 1;
    u_user.rd(0, 11'h21, 2, q);
    chk("gated_wr", q, 16'h5a3c);
    for (int k = 0; k < 4; k++) begin
      axw(ERB_CFG_OFS, {21'h0, bc[k]});
      rs = lfsr(rs);
      u_user.wr(11'h40 + k, rs[15:0]);
      u_user.rd(0, 11'h40 + k, bl[k], q);
      chk("bypass", q, rs[15:0]);
    end
    $display("enables done");
    axw(ERB_CFG_OFS, 32'hc);
    axw(ERB_PRE_ADDR_OFS, 32'h77);
    axw(ERB_PRE_DATA_OFS, 32'h9e15);
    u_user.wr(11'h77, 16'h1111);
    u_user.rd(0, 11'h77, 2, q);
    chk("lut_rd", q, 16'h9e15);
    axr(ERB_PRE_DATA_OFS);
    chk("lut_axi", rv, 32'h9e15);
    for (int k = 0; k < 2; k++) begin
      axw(ERB_CFG_OFS, 32'hc);
      u_user.rd(0, 11'h77, 2, q);
      @(posedge clk_i);
      local_clr_i <= (k == 0);
      global_clr_i <= (k == 1);
      @(posedge clk_i);
      #1 chk("clr_out", rd_data_o, 16'h0);
      @(posedge clk_i);
      local_clr_i <= 0;
      global_clr_i <= 0;
      axr(ERB_CFG_OFS);
      chk("clr_cfg", rv, {21'h0, ERB_CFG_RST});
    end
    $display("lookup and clear done");
    axw(ERB_CFG_OFS, 32'h14);
    @(posedge clk_i);
    rd_ce_i <= 0;
    u_user.rd(0, 11'h21, 2, q);
    chk("split_hold", q, 16'h0);
    rd_ce_i <= 1;
    @(posedge clk_i);
    #1 chk("split_out", rd_data_o, 16'h5a3c);
    axr(ERB_STATUS_OFS);
    chk("status", rv, 32'h5a3c);
    $display("split clocking done");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : erb_top_tb
bind erb_top erb_checker u_chk (.clk_i, .sys_rst_i, .local_clr_i, .global_clr_i,
  .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .wr_addr_i, .wr_ce_i, .rd_addr_i, .rd_en_i, .rd_ce_i,
  .blk_sel_i, .rd_data_o);
